// ===== design/octs_top.sv
// oscillator trim, fast oscillator calibration and timestamp capture
`timescale 1ns/10ps
module octs_top (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  // register port
  input  wire logic [15:0]          reg_addr,
  input  wire logic [15:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [15:0]               reg_rdata,
  output logic                      reg_rvalid,
  // oscillator cycle strobes and source select
  input  wire logic                 fast_tick,
  input  wire logic                 slow_tick,
  input  wire logic                 khz_source,
  // timestamp input and count sources
  input  wire logic                 first_general_pin,
  input  wire logic [31:0]          stamp_count,
  input  wire logic [15:0]          slot_remaining,
  // trim and enable outputs to the oscillators, and calibration busy status
  output logic [7:0]                fast_osc_trim_code,
  output logic [9:0]                slow_osc_trim_code,
  output logic [5:0]                khz_osc_trim_code,
  output logic                      calibration_clock_on,
  output logic                      calibration_busy
);

  // stored fields
  logic [7:0]  fast_trim_r;
  logic [9:0]  slow_trim_r;
  logic [5:0]  khz_trim_r;
  logic        clk_on_r;
  logic        go_r;
  logic [14:0] cal_total_r;
  logic        arm_r;
  logic        pin_prev_r;
  logic [15:0] capt_low_r;
  logic [15:0] capt_high_r;
  logic [15:0] remain_r;
  logic [15:0] rdata_r;
  logic        rvalid_r;

  // counter results
  logic        cal_done;
  logic        cal_busy;
  logic [14:0] cal_total;

  // address decode
  wire logic sel_fast  = (reg_addr == octs_pkg::FAST_OSC_TRIM_ADDR);
  wire logic sel_cal   = (reg_addr == octs_pkg::FAST_OSC_CAL_ADDR);
  wire logic sel_slow  = (reg_addr == octs_pkg::SLOW_OSC_TRIM_ADDR);
  wire logic sel_khz   = (reg_addr == octs_pkg::KHZ_TRIM_CAPT_ADDR);
  wire logic sel_low   = (reg_addr == octs_pkg::CAPT_LOW_ADDR);
  wire logic sel_high  = (reg_addr == octs_pkg::CAPT_HIGH_ADDR);
  wire logic sel_rem   = (reg_addr == octs_pkg::SLOT_REMAIN_ADDR);

  wire logic wr_fast   = reg_wr && sel_fast;
  wire logic wr_cal    = reg_wr && sel_cal;
  wire logic wr_slow   = reg_wr && sel_slow;
  wire logic wr_khz    = reg_wr && sel_khz;

  // software sets go and arm only by writing one; zero writes are ignored
  wire logic go_set    = wr_cal && reg_wdata[octs_pkg::CAL_GO_BIT];
  wire logic arm_set   = wr_khz && reg_wdata[octs_pkg::CAPT_ARM_BIT];

  // timestamp edge; pin is already synchronous to core_clk
  wire logic pin_rise  = first_general_pin && !pin_prev_r;
  wire logic capture   = arm_r && pin_rise;

  // read data assembly, unused bits stay zero
  wire logic [15:0] rd_fast = {8'h00, fast_trim_r};
  wire logic [15:0] rd_cal  = {go_r, cal_total_r};
  wire logic [15:0] rd_slow = {5'h00, clk_on_r, slow_trim_r};
  wire logic [15:0] rd_khz  = {arm_r, 9'h000, khz_trim_r};
  wire logic [15:0] rd_mux  =
    sel_fast ? rd_fast :
    sel_cal  ? rd_cal  :
    sel_slow ? rd_slow :
    sel_khz  ? rd_khz  :
    sel_low  ? capt_low_r  :
    sel_high ? capt_high_r :
    sel_rem  ? remain_r    :
    16'h0000;

  octs_cal_counter u_cal (
    .core_clk    (core_clk),
    .rst         (rst),
    .cal_request (go_r),
    .cal_enable  (clk_on_r),
    .khz_source  (khz_source),
    .fast_tick   (fast_tick),
    .slow_tick   (slow_tick),
    .cal_busy    (cal_busy),
    .cal_done    (cal_done),
    .cal_total   (cal_total)
  );

  // trim codes: plain stores, code ordering is the oscillator's own
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fast_trim_r <= octs_pkg::FAST_TRIM_RST;
      slow_trim_r <= octs_pkg::SLOW_TRIM_RST;
      khz_trim_r  <= octs_pkg::KHZ_TRIM_RST;
      clk_on_r    <= 1'b0;
    end else begin
      if (wr_fast) begin
        fast_trim_r <= reg_wdata[7:0];
      end
      if (wr_slow) begin
        slow_trim_r <= reg_wdata[9:0];
        clk_on_r    <= reg_wdata[octs_pkg::CAL_CLK_ON_BIT];
      end
      if (wr_khz) begin
        khz_trim_r <= reg_wdata[5:0];
      end
    end
  end

  // calibration go bit and result; a new go write beats the self-clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      go_r        <= 1'b0;
      cal_total_r <= octs_pkg::CAL_TOTAL_RST;
    end else begin
      if (go_set) begin
        go_r <= 1'b1;
      end else if (cal_done) begin
        go_r <= 1'b0;
      end
      if (cal_done) begin
        cal_total_r <= cal_total;
      end
    end
  end

  // timestamp arm and capture; arm write in the capture cycle rearms
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      arm_r       <= 1'b0;
      pin_prev_r  <= 1'b1;
      capt_low_r  <= octs_pkg::CAPT_RST;
      capt_high_r <= octs_pkg::CAPT_RST;
      remain_r    <= octs_pkg::CAPT_RST;
    end else begin
      pin_prev_r <= first_general_pin;
      if (arm_set) begin
        arm_r <= 1'b1;
      end else if (capture) begin
        arm_r <= 1'b0;
      end
      if (capture) begin
        capt_low_r  <= stamp_count[15:0];
        capt_high_r <= stamp_count[31:16];
        remain_r    <= slot_remaining;
      end
    end
  end

  // registered read answer, one cycle after the strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_r  <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_rd;
      if (reg_rd) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign reg_rdata            = rdata_r;
  assign reg_rvalid           = rvalid_r;
  assign fast_osc_trim_code   = fast_trim_r;
  assign slow_osc_trim_code   = slow_trim_r;
  assign khz_osc_trim_code    = khz_trim_r;
  assign calibration_clock_on = clk_on_r;
  assign calibration_busy     = cal_busy;

endmodule

// ===== design/octs_pkg.sv
// constants for oscillator trim, calibration and timestamp capture
// Contract
// - fast trim 8 bits, monotonic, resets 0x90
// - writing one to go starts calibration
// - slow 1 MHz source: 128-cycle window
// - 32 kHz source: 32-cycle window instead
// - total loads 15-bit count, held until next
// - go bit self-clears when calibration completes
// - calibration disabled while clock-on bit zero
// - slow trim 10 bits, resets 0x2B2
// - armed capture on next timestamp rising edge
// - arm bit clears itself on capture
// - khz trim 6 bits, 0 fastest, resets 0x12
// - captured count read as two 16-bit halves
// - read-only remaining count to next slot
package octs_pkg;

  // register port
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;

  // register addresses
  localparam logic [15:0] FAST_OSC_TRIM_ADDR   = 16'h0009;
  localparam logic [15:0] FAST_OSC_CAL_ADDR    = 16'h000A;
  localparam logic [15:0] SLOW_OSC_TRIM_ADDR   = 16'h000B;
  localparam logic [15:0] KHZ_TRIM_CAPT_ADDR   = 16'h000C;
  localparam logic [15:0] CAPT_LOW_ADDR        = 16'h0011;
  localparam logic [15:0] CAPT_HIGH_ADDR       = 16'h0012;
  localparam logic [15:0] SLOT_REMAIN_ADDR     = 16'h0013;

  // field widths and positions
  localparam int FAST_TRIM_W     = 8;
  localparam int SLOW_TRIM_W     = 10;
  localparam int KHZ_TRIM_W      = 6;
  localparam int CAL_TOTAL_W     = 15;
  localparam int CAL_GO_BIT      = 15;
  localparam int CAL_CLK_ON_BIT  = 10;
  localparam int CAPT_ARM_BIT    = 15;
  localparam int STAMP_W         = 32;

  // values after reset
  localparam logic [7:0]  FAST_TRIM_RST  = 8'h90;
  localparam logic [9:0]  SLOW_TRIM_RST  = 10'h2B2;
  localparam logic [5:0]  KHZ_TRIM_RST   = 6'h12;
  localparam logic [14:0] CAL_TOTAL_RST  = 15'h0000;
  localparam logic [15:0] CAPT_RST       = 16'h0000;

  // calibration windows in slow oscillator cycles, and the total saturation limit
  localparam logic [7:0]  WIN_SLOW_MHZ   = 8'h80;
  localparam logic [7:0]  WIN_SLOW_KHZ   = 8'h20;
  localparam logic [14:0] CAL_TOTAL_MAX  = 15'h7FFF;

  typedef enum logic [3:0] {
    CAL_IDLE  = 4'b0001,
    CAL_ALIGN = 4'b0010,
    CAL_COUNT = 4'b0100,
    CAL_DONE  = 4'b1000
  } octs_cal_state_e;

endpackage

// ===== design/octs_cal_counter.sv
// counts fast oscillator cycles over a window of slow oscillator cycles
`timescale 1ns/10ps
module octs_cal_counter (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  // control
  input  wire logic                 cal_request,
  input  wire logic                 cal_enable,
  input  wire logic                 khz_source,
  // oscillator cycle strobes
  input  wire logic                 fast_tick,
  input  wire logic                 slow_tick,
  // result
  output logic                      cal_busy,
  output logic                      cal_done,
  output logic [14:0]               cal_total
);

  octs_pkg::octs_cal_state_e state_r, state_nxt;
  logic [14:0] total_r;
  logic [7:0]  slow_cnt_r;

  wire logic [7:0] window_len = khz_source ? octs_pkg::WIN_SLOW_KHZ
                                           : octs_pkg::WIN_SLOW_MHZ;
  wire logic       last_slow  = slow_tick &&
                                (slow_cnt_r == window_len - 8'h01);
  wire logic       total_full = (total_r == octs_pkg::CAL_TOTAL_MAX);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      octs_pkg::CAL_IDLE: begin
        if (cal_request && cal_enable) begin
          state_nxt = octs_pkg::CAL_ALIGN;
        end
      end
      // window opens on a slow edge so it spans whole slow cycles
      octs_pkg::CAL_ALIGN: begin
        if (!cal_enable) begin
          state_nxt = octs_pkg::CAL_IDLE;
        end else if (slow_tick) begin
          state_nxt = octs_pkg::CAL_COUNT;
        end
      end
      octs_pkg::CAL_COUNT: begin
        if (!cal_enable) begin
          state_nxt = octs_pkg::CAL_IDLE;
        end else if (last_slow) begin
          state_nxt = octs_pkg::CAL_DONE;
        end
      end
      octs_pkg::CAL_DONE: begin
        state_nxt = octs_pkg::CAL_IDLE;
      end
      default: begin
        state_nxt = octs_pkg::CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r    <= octs_pkg::CAL_IDLE;
      total_r    <= octs_pkg::CAL_TOTAL_RST;
      slow_cnt_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      if (state_r == octs_pkg::CAL_ALIGN) begin
        total_r    <= octs_pkg::CAL_TOTAL_RST;
        slow_cnt_r <= 8'h00;
      end else if (state_r == octs_pkg::CAL_COUNT) begin
        // saturate rather than wrap on an over-fast oscillator
        if (fast_tick && !total_full) begin
          total_r <= total_r + 15'h0001;
        end
        if (slow_tick) begin
          slow_cnt_r <= slow_cnt_r + 8'h01;
        end
      end
    end
  end

  assign cal_busy  = (state_r != octs_pkg::CAL_IDLE);
  assign cal_done  = (state_r == octs_pkg::CAL_DONE);
  assign cal_total = total_r;

endmodule

// ===== testbench/octs_asserts.sv
// port-level assertions for trim, calibration and capture block
`timescale 1ns/10ps
module octs_asserts (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // register port
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic        reg_rvalid,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  // oscillator controls
  input wire logic [7:0]  fast_osc_trim_code,
  input wire logic [9:0]  slow_osc_trim_code,
  input wire logic [5:0]  khz_osc_trim_code,
  input wire logic        calibration_clock_on,
  input wire logic        calibration_busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire w9 = reg_wr && reg_addr == 16'h0009;
  fast_trim_wr_a: assert property (w9 |=>
    fast_osc_trim_code == $past(reg_wdata[7:0])) else $error("fast trim");
  fast_trim_hold_a: assert property (!w9 |=>
    $stable(fast_osc_trim_code)) else $error("fast trim moved");
  slow_trim_wr_a: assert property (reg_wr && reg_addr == 16'h000B |=>
    {calibration_clock_on, slow_osc_trim_code} == $past(reg_wdata[10:0]))
    else $error("slow trim or clock enable");
  khz_trim_wr_a: assert property (reg_wr && reg_addr == 16'h000C |=>
    khz_osc_trim_code == $past(reg_wdata[5:0])) else $error("khz trim");
  cal_off_idle_a: assert property (!calibration_clock_on [*2] |->
    !calibration_busy) else $error("busy while disabled");
  fast_read_a: assert property (reg_rd && reg_addr == 16'h0009 |=>
    reg_rdata == {8'h00, $past(fast_osc_trim_code)}) else $error("rd 9");
  khz_read_a: assert property (reg_rd && reg_addr == 16'h000C |=>
    reg_rdata[14:0] == {9'h000, $past(khz_osc_trim_code)})
    else $error("rd C");
  unmapped_zero_a: assert property (reg_rd && !(reg_addr inside
    {16'h0009, 16'h000A, 16'h000B, 16'h000C, 16'h0011, 16'h0012,
    16'h0013}) |=> reg_rdata == 16'h0000) else $error("unmapped read");
  rdata_hold_a: assert property (!reg_rvalid |->
    $stable(reg_rdata)) else $error("read data moved");
  rd_valid_a: assert property (reg_rvalid == $past(reg_rd))
    else $error("read valid timing");
  cal_start_a: assert property (reg_wr && reg_addr == 16'h000A &&
    reg_wdata[15] && calibration_clock_on && !calibration_busy |=> ##1
    calibration_busy) else $error("calibration did not start");
endmodule
bind octs_top octs_asserts chk (.*);

// ===== testbench/octs_pulse_src.sv
// oscillator tick and timestamp pulse source beside the block
`timescale 1ns/10ps
module octs_pulse_src (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // control from bench
  input  wire logic [3:0] period,
  input  wire logic       fire,
  // outputs to the block
  output logic            fast_tick,
  output logic            slow_tick,
  output logic            pin
);
  logic [3:0] cnt_r;
  logic [1:0] hold_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_r  <= 4'h0;
      hold_r <= 2'h0;
    end else begin
      cnt_r  <= (cnt_r >= period - 4'h1) ? 4'h0 : cnt_r + 4'h1;
      hold_r <= fire ? 2'h3 : hold_r - {1'b0, hold_r != 2'h0};
    end
  end
  // fast ticks every cycle so a window total is exactly window * period
  assign fast_tick = !rst;
  assign slow_tick = !rst && cnt_r == period - 4'h1;
  assign pin       = hold_r != 2'h0;
endmodule

// ===== testbench/test_osc_cal_and_timestamp.sv
// self-checking bench for trim, calibration and timestamp capture
`timescale 1ns/10ps
`define CHK(g, e, m) begin tests_run++; if ((g) !== (e)) begin \
  num_errors++; $display("CHECK FAILED %0t %s", $time, m); end end
module test_osc_cal_and_timestamp;
  logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, khz_source = 0;
  logic fire = 0, fast_tick, slow_tick, pin, reg_rvalid, cal_on, busy;
  logic [15:0] reg_addr = 0, reg_wdata = 0, reg_rdata, slot_rem = 0, v, d;
  logic [31:0] stamp = 0;
  logic [7:0]  ft;
  logic [9:0]  st;
  logic [5:0]  kt;
  logic [3:0]  period = 4'h3;
  logic [15:0] sh [3], ex [3];
  logic [15:0] ta [3] = '{16'h0009, 16'h000B, 16'h000C};
  logic [15:0] ra [8] = '{16'h0009, 16'h000A, 16'h000B, 16'h000C,
                          16'h0011, 16'h0012, 16'h0013, 16'h000D};
  logic [15:0] re [8] = '{16'h0090, 16'h0000, 16'h02B2, 16'h0012,
                          16'h0000, 16'h0000, 16'h0000, 16'h0000};
  int num_errors = 0, tests_run = 0, i, n;
  octs_top dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .fast_tick(fast_tick),
    .slow_tick(slow_tick), .khz_source(khz_source),
    .first_general_pin(pin), .stamp_count(stamp), .slot_remaining(slot_rem),
    .fast_osc_trim_code(ft), .slow_osc_trim_code(st),
    .khz_osc_trim_code(kt), .calibration_clock_on(cal_on),
    .calibration_busy(busy));
  octs_pulse_src src (.core_clk(core_clk), .rst(rst), .period(period),
    .fire(fire), .fast_tick(fast_tick), .slow_tick(slow_tick), .pin(pin));
  initial forever #50 core_clk = ~core_clk;
  task tally_and_finish;
    if (num_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #5000000;
    num_errors++;
    tally_and_finish();
  end
  task wr(input logic [15:0] a, w);
    @(posedge core_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge core_clk);
    reg_wr <= 0;
  endtask
  task rd(input logic [15:0] a, output logic [15:0] q);
    @(posedge core_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 0;
    #1 q = reg_rdata;
  endtask
  task pulse;
    @(posedge core_clk);
    fire <= 1;
    @(posedge core_clk);
    fire <= 0;
    repeat (6) @(posedge core_clk);
  endtask
  function logic [15:0] masked(input logic [15:0] a, w);
    case (a)
      16'h0009: masked = {8'h00, w[7:0]};
      16'h000B: masked = {5'h00, w[10:0]};
      default:  masked = {10'h000, w[5:0]};
    endcase
  endfunction
  function logic [15:0] cal_exp(input logic k, input logic [3:0] p);
    cal_exp = (k ? 16'h0020 : 16'h0080) * {12'h000, p};
  endfunction
  initial begin
    void'($urandom(84));
    repeat (12) @(posedge core_clk);
    rst <= 0;
    for (i = 0; i < 8; i++) begin
      rd(ra[i], v);
      `CHK(v, re[i], "reset value")
    end
    wr(16'h0011, 16'hFFFF);
    rd(16'h0011, v);
    `CHK(v, 16'h0000, "read-only write")
    // all-ones and all-zero codes first, then random ones
    for (i = 0; i < 9; i++) begin
      d = i < 3 ? 16'hFFFF : i < 6 ? 16'h0000 : 16'($urandom);
      if (i % 3 == 2) d[15] = 1'b0;
      wr(ta[i % 3], d);
      sh[i % 3] = masked(ta[i % 3], d);
      rd(ta[i % 3], v);
      `CHK(v, sh[i % 3], "trim readback")
    end
    `CHK({ft, st, kt}, {sh[0][7:0], sh[1][9:0], sh[2][5:0]}, "trims")
    wr(16'h000B, sh[1] & 16'hFBFF);
    wr(16'h000A, 16'h8000);
    repeat (200) @(posedge core_clk);
    rd(16'h000A, v);
    `CHK({busy, v}, {1'b0, 16'h8000}, "held off")
    for (i = 0; i < 2; i++) begin
      @(posedge core_clk);
      period <= 4'h2 + 4'($urandom % 6);
      khz_source <= i[0];
      if (i == 0) wr(16'h000B, sh[1] | 16'h0400);
      else wr(16'h000A, 16'h8000);
      n = 0;
      do begin rd(16'h000A, v); n++; end while (v[15] && n < 2000);
      `CHK(v, cal_exp(i[0], period), "cal total")
    end
    @(posedge core_clk);
    stamp <= $urandom;
    slot_rem <= 16'($urandom);
    pulse();
    rd(16'h0011, v);
    `CHK(v, 16'h0000, "unarmed edge")
    wr(16'h000C, 16'h8000 | sh[2]);
    ex = '{stamp[15:0], stamp[31:16], slot_rem};
    pulse();
    stamp <= $urandom;
    for (i = 0; i < 3; i++) begin
      rd(16'h0011 + 16'(i), v);
      `CHK(v, ex[i], "capture")
    end
    rd(16'h000C, v);
    `CHK(v, sh[2], "arm cleared")
    tally_and_finish();
  end
endmodule
